//--- rf_input_select_cfg.svh
// Constants for the RF input select control block: offsets, fields, resets, timing.
// Assumes a 125 MHz mclk and a host that frames serial transfers with chip select.
//
// Contract
// - Register rf_input_path_control bit 11 chooses pins or serial field to steer the input switch.
// - The source-select bit resets to zero, so serial control applies after power-up.
// - With source-select low, field bits 10:9 pick input zero to three; pins ignored.
// - With source-select high, pins high-then-low pick the input; field ignored.
// - Under pin control the switch changes within 100 ns of a pin change.
// - Under serial control the switch settles 100 ns after the write takes effect.
// - Register balun_tuning holds primary cap code in bits 3:1, secondary in 7:5.
// - Primary and secondary balun cap codes are independently writable.
// - Register rf_input_path_control bits 8:5 set the step attenuator, 0 to 15 dB.
`ifndef RF_INPUT_SELECT_CFG_SVH
`define RF_INPUT_SELECT_CFG_SVH

`define SPI_ADDR_BITS        7
`define SPI_DATA_BITS        16
`define SPI_FRAME_BITS       24
`define SPI_CMD_LAST_BIT     5'h07
`define SPI_FRAME_LAST_BIT   5'h17

`define RF_PATH_CTRL_ADDR    7'h23
`define BALUN_TUNING_ADDR    7'h30

`define SRC_SEL_BIT          11
`define SEL_FIELD_MSB        10
`define SEL_FIELD_LSB        9
`define ATTEN_MSB            8
`define ATTEN_LSB            5
`define BAL_PRI_MSB          3
`define BAL_PRI_LSB          1
`define BAL_SEC_MSB          7
`define BAL_SEC_LSB          5

`define SRC_SEL_RESET        1'b0
`define SEL_FIELD_RESET      2'h0
`define ATTEN_RESET          4'h0
`define BAL_CAP_RESET        3'h0

`define SWITCH_SETTLE_NS     100
`define MCLK_PERIOD_PS       8000

`endif

//--- rf_input_select_pkg.sv
// Types shared by the RF input select control block.
// Constants live in rf_input_select_cfg.svh.
package rf_input_select_pkg;

  typedef logic [1:0] input_index_t;
  typedef logic [3:0] atten_code_t;
  typedef logic [2:0] cap_code_t;
  typedef logic [3:0] port_enable_t;

  typedef enum logic [1:0] {
    SPI_IDLE    = 2'b00,
    SPI_COMMAND = 2'b01,
    SPI_WRITE   = 2'b10,
    SPI_READ    = 2'b11
  } spi_state_t;

  typedef struct packed {
    logic         input_switch_source_select;
    input_index_t input_select_field;
    atten_code_t  step_attenuation_code;
  } rf_path_ctrl_t;

  typedef struct packed {
    cap_code_t balun_secondary_cap_code;
    cap_code_t balun_primary_cap_code;
  } balun_tuning_t;

endpackage

//--- sync_stage.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/1ps
module sync_stage #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta     <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sync_stage

//--- switch_drive.sv
// Drives the one-hot input switch and flags the settle window after a change.
// Assumes the selected index is already synchronous to mclk.
`timescale 1ns/1ps
`include "rf_input_select_cfg.svh"
module switch_drive
  import rf_input_select_pkg::*;
#(
  parameter int SETTLE_NS = `SWITCH_SETTLE_NS
) (
  input  wire logic                               mclk,
  input  wire logic                               rst_b,
  input  wire rf_input_select_pkg::input_index_t  select,
  output rf_input_select_pkg::port_enable_t       port_enable,
  output rf_input_select_pkg::input_index_t       active_index,
  output logic                                    settling
);

  // Least time, so round up to whole cycles
  localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS;
  localparam logic [4:0] SETTLE_LOAD = 5'(SETTLE_CYCLES);

  logic [4:0] settle_count;

  // One-hot drive, registered one cycle after the select moves
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      port_enable  <= 4'h1;
      active_index <= 2'h0;
    end else begin
      port_enable  <= 4'(4'h1 << select);
      active_index <= select;
    end
  end

  // Settle window restarts on every change
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      settle_count <= 5'h00;
    end else if (select != active_index) begin
      settle_count <= SETTLE_LOAD;
    end else if (settle_count != 5'h00) begin
      settle_count <= settle_count - 5'h01;
    end
  end

  assign settling = (settle_count != 5'h00);

endmodule // switch_drive

//--- rf_input_select_control.sv
// RF input path control: serial register slave, input switch steering,
// balun capacitor codes and step attenuator code.
// Assumes a 3-wire serial host and external logic on the two select pins,
// all asynchronous to mclk; serial clock phases must each last 3 mclk cycles.
`timescale 1ns/1ps
`include "rf_input_select_cfg.svh"
module rf_input_select_control
  import rf_input_select_pkg::*;
(
  input  wire logic                              mclk,
  input  wire logic                              rst_b,
  // Serial port
  input  wire logic                              spi_sclk,
  input  wire logic                              spi_cs_b,
  input  wire logic                              spi_sdio_in,
  output logic                                   spi_sdio_out,
  output logic                                   spi_sdio_oe_b,
  // Select pins
  input  wire logic                              input_select_pin_high,
  input  wire logic                              input_select_pin_low,
  // Analog controls
  output rf_input_select_pkg::port_enable_t      input_port_enable,
  output rf_input_select_pkg::input_index_t      active_input,
  output logic                                   switch_settling,
  output logic                                   input_switch_source_select,
  output rf_input_select_pkg::cap_code_t         balun_primary_cap_code,
  output rf_input_select_pkg::cap_code_t         balun_secondary_cap_code,
  output rf_input_select_pkg::atten_code_t       step_attenuation_code
);

  import rf_input_select_pkg::*;

  logic                          sclk_s;
  logic                          sdio_s;
  logic                          pin_high_s;
  logic                          pin_low_s;
  logic                          cs_b_s;
  logic                          sclk_d;
  logic                          sclk_rise;
  logic                          sclk_fall;
  spi_state_t                    state;
  spi_state_t                    next_state;
  logic [4:0]                    bit_count;
  logic [`SPI_FRAME_BITS-2:0]    shift_in;
  logic [`SPI_FRAME_BITS-1:0]    next_shift;
  logic [`SPI_ADDR_BITS-1:0]     addr;
  logic [`SPI_DATA_BITS-1:0]     read_shift;
  logic [`SPI_DATA_BITS-1:0]     read_word;
  logic                          write_strobe;
  logic [`SPI_DATA_BITS-1:0]     write_data;
  rf_path_ctrl_t                 path_ctrl;
  balun_tuning_t                 balun;
  input_index_t                  pin_index;
  input_index_t                  selected_index;

  // Everything from outside passes two flops first
  sync_stage #(
    .WIDTH       (4),
    .RESET_VALUE (4'h0)
  ) u_sync_data (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in ({spi_sclk, spi_sdio_in, input_select_pin_high, input_select_pin_low}),
    .sync_out ({sclk_s, sdio_s, pin_high_s, pin_low_s})
  );

  // Chip select idles deasserted through reset
  sync_stage #(
    .WIDTH       (1),
    .RESET_VALUE (1'b1)
  ) u_sync_cs (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (spi_cs_b),
    .sync_out (cs_b_s)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  assign sclk_rise  = sclk_s & ~sclk_d;
  assign sclk_fall  = ~sclk_s & sclk_d;
  assign next_shift = {shift_in, sdio_s};

  // Frame: read flag, 7 address bits, 16 data bits, MSB first
  always_comb begin
    next_state = state;
    case (state)
      SPI_IDLE: begin
        if (!cs_b_s) begin
          next_state = SPI_COMMAND;
        end
      end
      SPI_COMMAND: begin
        if (sclk_rise && bit_count == `SPI_CMD_LAST_BIT) begin
          next_state = next_shift[`SPI_ADDR_BITS] ? SPI_READ : SPI_WRITE;
        end
      end
      SPI_WRITE: begin
        if (sclk_rise && bit_count == `SPI_FRAME_LAST_BIT) begin
          next_state = SPI_IDLE;
        end
      end
      SPI_READ: begin
        next_state = SPI_READ;
      end
      default: begin
        next_state = SPI_IDLE;
      end
    endcase
    // Deselect aborts any partial frame
    if (cs_b_s) begin
      next_state = SPI_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SPI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter and input shifter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_count <= 5'h00;
      shift_in  <= '0;
    end else if (cs_b_s) begin
      bit_count <= 5'h00;
    end else if (sclk_rise && state != SPI_IDLE) begin
      bit_count <= bit_count + 5'h01;
      shift_in  <= next_shift[`SPI_FRAME_BITS-2:0];
    end
  end

  // Address latched at the end of the command phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr <= '0;
    end else if (state == SPI_COMMAND && sclk_rise && bit_count == `SPI_CMD_LAST_BIT) begin
      addr <= next_shift[`SPI_ADDR_BITS-1:0];
    end
  end

  // Write takes effect on the last data bit; a short frame writes nothing
  assign write_strobe = (state == SPI_WRITE) && sclk_rise && (bit_count == `SPI_FRAME_LAST_BIT);
  assign write_data   = next_shift[`SPI_DATA_BITS-1:0];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      path_ctrl.input_switch_source_select <= `SRC_SEL_RESET;
      path_ctrl.input_select_field         <= `SEL_FIELD_RESET;
      path_ctrl.step_attenuation_code      <= `ATTEN_RESET;
    end else if (write_strobe && addr == `RF_PATH_CTRL_ADDR) begin
      path_ctrl.input_switch_source_select <= write_data[`SRC_SEL_BIT];
      path_ctrl.input_select_field         <= write_data[`SEL_FIELD_MSB:`SEL_FIELD_LSB];
      path_ctrl.step_attenuation_code      <= write_data[`ATTEN_MSB:`ATTEN_LSB];
    end
  end

  // Both codes share one word; each is its own field, so either may be changed
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      balun.balun_primary_cap_code   <= `BAL_CAP_RESET;
      balun.balun_secondary_cap_code <= `BAL_CAP_RESET;
    end else if (write_strobe && addr == `BALUN_TUNING_ADDR) begin
      balun.balun_primary_cap_code   <= write_data[`BAL_PRI_MSB:`BAL_PRI_LSB];
      balun.balun_secondary_cap_code <= write_data[`BAL_SEC_MSB:`BAL_SEC_LSB];
    end
  end

  // Readback; unused bits and unmapped addresses read zero
  always_comb begin
    read_word = '0;
    case (next_shift[`SPI_ADDR_BITS-1:0])
      `RF_PATH_CTRL_ADDR: begin
        read_word[`SRC_SEL_BIT]                 = path_ctrl.input_switch_source_select;
        read_word[`SEL_FIELD_MSB:`SEL_FIELD_LSB] = path_ctrl.input_select_field;
        read_word[`ATTEN_MSB:`ATTEN_LSB]         = path_ctrl.step_attenuation_code;
      end
      `BALUN_TUNING_ADDR: begin
        read_word[`BAL_PRI_MSB:`BAL_PRI_LSB] = balun.balun_primary_cap_code;
        read_word[`BAL_SEC_MSB:`BAL_SEC_LSB] = balun.balun_secondary_cap_code;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // Data leaves on falling edges so the host samples it on rising edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      read_shift    <= '0;
      spi_sdio_out  <= 1'b0;
      spi_sdio_oe_b <= 1'b1;
    end else if (cs_b_s) begin
      spi_sdio_out  <= 1'b0;
      spi_sdio_oe_b <= 1'b1;
    end else if (state == SPI_COMMAND && sclk_rise && bit_count == `SPI_CMD_LAST_BIT) begin
      read_shift <= read_word;
    end else if (state == SPI_READ && sclk_fall) begin
      spi_sdio_out  <= read_shift[`SPI_DATA_BITS-1];
      read_shift    <= {read_shift[`SPI_DATA_BITS-2:0], 1'b0};
      spi_sdio_oe_b <= 1'b0;
    end
  end

  // Pin pair decodes high then low
  assign pin_index = {pin_high_s, pin_low_s};

  // Source select chooses the steering path
  assign selected_index = path_ctrl.input_switch_source_select ? pin_index
                                                               : path_ctrl.input_select_field;

  // Pin path: 2 sync + 1 drive cycle = 24 ns, inside the 100 ns budget
  switch_drive #(
    .SETTLE_NS (`SWITCH_SETTLE_NS)
  ) u_switch_drive (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .select       (selected_index),
    .port_enable  (input_port_enable),
    .active_index (active_input),
    .settling     (switch_settling)
  );

  assign input_switch_source_select = path_ctrl.input_switch_source_select;
  assign balun_primary_cap_code     = balun.balun_primary_cap_code;
  assign balun_secondary_cap_code   = balun.balun_secondary_cap_code;
  // Code is the attenuation in dB, applied unchanged
  assign step_attenuation_code      = path_ctrl.step_attenuation_code;

endmodule // rf_input_select_control

//--- rf_input_select_control_chk.sv
// Port-level assertions for rf_input_select_control, bound below.
// Assumes a host that holds spi_cs_b high between frames.
`timescale 1ns/1ps
module rf_input_select_control_chk
  import rf_input_select_pkg::*;
(
  input wire logic                              mclk,
  input wire logic                              rst_b,
  input wire logic                              spi_cs_b,
  input wire logic                              spi_sdio_oe_b,
  input wire logic                              input_select_pin_high,
  input wire logic                              input_select_pin_low,
  input wire rf_input_select_pkg::port_enable_t input_port_enable,
  input wire rf_input_select_pkg::input_index_t active_input,
  input wire logic                              switch_settling,
  input wire logic                              input_switch_source_select,
  input wire rf_input_select_pkg::cap_code_t    balun_primary_cap_code,
  input wire rf_input_select_pkg::cap_code_t    balun_secondary_cap_code,
  input wire rf_input_select_pkg::atten_code_t  step_attenuation_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [1:0] pins;
  logic       src;
  assign pins = {input_select_pin_high, input_select_pin_low};
  assign src = input_switch_source_select;

  a_reset_serial: assert property ($rose(rst_b) |-> !src && active_input == 2'h0)
    else $error("reset state not serial input zero");
  a_enable_onehot: assert property (input_port_enable == 4'h1 << active_input)
    else $error("switch drive not one-hot of index");
  // Pins wander freely in serial mode, so a change here is a leak
  a_serial_ignores_pins: assert property ((!src && spi_cs_b)[*8] |-> $stable(active_input))
    else $error("index moved under serial control");
  a_pin_switch_time: assert property ((src && $changed(pins)) ##1 (src && $stable(pins))[*4]
    |-> active_input == pins) else $error("pins not followed in time");
  a_settle_hold: assert property ($changed(active_input) |-> ##1 switch_settling[*8])
    else $error("settle window dropped early");
  a_settle_end: assert property ($changed(active_input) |-> ##[12:14] !switch_settling)
    else $error("settle window too long");
  a_regs_quiet: assert property (spi_cs_b[*6] |-> $stable({src, step_attenuation_code,
    balun_primary_cap_code, balun_secondary_cap_code})) else $error("register moved without frame");
  a_oe_idle: assert property (spi_cs_b[*5] |-> spi_sdio_oe_b)
    else $error("data line driven while deselected");

  c_pin_change: cover property (src && $changed(active_input));
  c_serial_change: cover property (!src && $changed(active_input));
  c_read_drive: cover property ($fell(spi_sdio_oe_b));
endmodule // rf_input_select_control_chk

bind rf_input_select_control rf_input_select_control_chk chk (
  .mclk, .rst_b, .spi_cs_b, .spi_sdio_oe_b, .input_select_pin_high, .input_select_pin_low,
  .input_port_enable, .active_input, .switch_settling, .input_switch_source_select,
  .balun_primary_cap_code, .balun_secondary_cap_code, .step_attenuation_code
);

//--- rf_host_model.sv
// Host model: serial master and select-pin logic facing the block.
// Assumes mclk; each serial clock high phase lasts PHASE mclk cycles, each low phase PHASE+1.
`timescale 1ns/1ps
module rf_host_model #(
  parameter int PHASE = 6
) (
  input  wire logic mclk,
  input  wire logic spi_sdio_out,
  input  wire logic spi_sdio_oe_b,
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      spi_sdio_in,
  output logic      input_select_pin_high,
  output logic      input_select_pin_low
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_sdio_in = 1'b0;
    {input_select_pin_high, input_select_pin_low} = 2'h0;
  end

  task automatic set_pins(input logic [1:0] v);
    @(posedge mclk);
    {input_select_pin_high, input_select_pin_low} <= v;
  endtask

  // Read bits are taken on the rising edge after they were shifted out
  task automatic frame(input logic [23:0] word, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge mclk) spi_cs_b <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge mclk) spi_sdio_in <= word[i];
      repeat (PHASE) @(posedge mclk);
      spi_sclk <= 1'b1;
      // Undriven line reads inverted, so a missing enable cannot pass
      if (i < 16) rd[i] = spi_sdio_oe_b ? ~spi_sdio_out : spi_sdio_out;
      repeat (PHASE) @(posedge mclk);
      spi_sclk <= 1'b0;
    end
    repeat (PHASE) @(posedge mclk);
    spi_cs_b <= 1'b1;
    spi_sdio_in <= ~spi_sdio_in;
    repeat (PHASE) @(posedge mclk);
  endtask
endmodule // rf_host_model

//--- rf_input_select_control_bench.sv
// Self-checking bench for rf_input_select_control.
// Assumes rf_host_model supplies serial frames and select pins.
`timescale 1ns/1ps
module rf_input_select_control_bench;
  import rf_input_select_pkg::*;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic         spi_sclk, spi_cs_b, spi_sdio_in, spi_sdio_out, spi_sdio_oe_b;
  logic         input_select_pin_high, input_select_pin_low, switch_settling, input_switch_source_select;
  port_enable_t input_port_enable;
  input_index_t active_input;
  cap_code_t    balun_primary_cap_code, balun_secondary_cap_code;
  atten_code_t  step_attenuation_code;
  logic         e_src = 1'b0;
  logic [1:0]   e_field = 2'h0, e_pins = 2'h0;
  logic [3:0]   e_atten = 4'h0;
  logic [2:0]   e_pri = 3'h0, e_sec = 3'h0;
  logic [15:0]  rd_word;
  logic [17:0]  notes[$];
  logic [17:0]  note;
  event         result_seen;
  int           n_mismatch = 0, n_tests = 0, seed = 41, cycles = 0;

  rf_input_select_control dut (.mclk, .rst_b, .spi_sclk, .spi_cs_b, .spi_sdio_in, .spi_sdio_out,
    .spi_sdio_oe_b, .input_select_pin_high, .input_select_pin_low, .input_port_enable, .active_input,
    .switch_settling, .input_switch_source_select, .balun_primary_cap_code, .balun_secondary_cap_code,
    .step_attenuation_code);
  rf_host_model host (.mclk, .spi_sdio_out, .spi_sdio_oe_b, .spi_sclk, .spi_cs_b, .spi_sdio_in,
    .input_select_pin_high, .input_select_pin_low);

  always #4 mclk = ~mclk;

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic compare_state(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t state got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_read(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t read got %h expected %h", $time, got, exp);
    end
  endtask

  // Oldest note first: results arrive in the order they were requested
  always begin
    @(result_seen);
    note = notes.pop_front();
    if (note[17]) compare_read(rd_word, note[15:0]);
    else compare_state({input_switch_source_select, active_input, step_attenuation_code,
      balun_primary_cap_code, balun_secondary_cap_code, input_port_enable}, note[16:0]);
  end

  function automatic logic [16:0] model_state();
    logic [1:0] idx;
    idx = e_src ? e_pins : e_field;
    return {e_src, idx, e_atten, e_pri, e_sec, 4'h1 << idx};
  endfunction

  task automatic expect_state();
    notes.push_back({1'b0, model_state()});
    @(negedge mclk) -> result_seen;
  endtask

  task automatic read_check(input logic [6:0] a, input logic [15:0] exp);
    host.frame({1'b1, a, 16'h0000}, rd_word);
    notes.push_back({2'b10, exp});
    @(negedge mclk) -> result_seen;
  endtask

  task automatic write_ctrl();
    host.frame({1'b0, 7'h23, 4'($random(seed)), e_src, e_field, e_atten, 5'($random(seed))}, rd_word);
    expect_state();
  endtask

  task automatic balun_step(input logic [2:0] p, input logic [2:0] s);
    e_pri = p;
    e_sec = s;
    host.frame({1'b0, 7'h30, 8'($random(seed)), s, 1'($random(seed)), p, 1'($random(seed))}, rd_word);
    expect_state();
  endtask

  task automatic pins(input logic [1:0] v);
    e_pins = v;
    host.set_pins(v);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    expect_state();
    for (int f = 0; f < 4; f++) begin
      pins(2'($random(seed)));
      e_field = 2'(f);
      e_atten = (f == 0) ? 4'h0 : (f == 3) ? 4'hf : 4'($random(seed));
      write_ctrl();
    end
    read_check(7'h23, {4'h0, e_src, e_field, e_atten, 5'h00});
    balun_step(3'($random(seed)), 3'($random(seed)));
    balun_step(~e_pri, e_sec);
    balun_step(e_pri, ~e_sec);
    read_check(7'h30, {8'h00, e_sec, 1'b0, e_pri, 1'b0});
    host.frame({1'b0, 7'h31, 16'hffff}, rd_word);
    expect_state();
    read_check(7'h31, 16'h0000);
    e_src = 1'b1;
    e_field = 2'h2;
    write_ctrl();
    for (int v = 0; v < 4; v++) begin
      pins(e_pins + 2'h1);
      repeat (12) @(posedge mclk);
      expect_state();
      repeat (8) @(posedge mclk);
    end
    e_src = 1'b0;
    write_ctrl();
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule // rf_input_select_control_bench
